// [logic/alarm_filter_config.v]
// alarm-filter configuration bank with channel select, ready pin and amplifier cut-off
// assumes an Avalon-MM master on MCLK_I and alarm samples from converter logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "alarm_filter_consts.vh"
module alarm_filter_config #(
    parameter ADDR_WIDTH = 8,
    parameter NUM_IN = `NUM_INPUTS
) (
    // clock and reset
    input wire MCLK_I,
    input wire RESETN_I,
    // avalon-mm slave
    input wire [ADDR_WIDTH-1:0] AVS_ADDRESS_I,
    input wire AVS_READ_I,
    input wire AVS_WRITE_I,
    input wire [31:0] AVS_WRITEDATA_I,
    input wire [3:0] AVS_BYTEENABLE_I,
    output wire [31:0] AVS_READDATA_O,
    output wire AVS_WAITREQUEST_O,
    // converter samples
    input wire SAMPLE_VALID_I,
    input wire [3:0] SAMPLE_CHAN_I,
    input wire SAMPLE_OUT_OF_RANGE_I,
    // conversion sequencing
    input wire CONV_START_I,
    input wire CONV_DONE_I,
    output wire CONV_REQ_O,
    output wire [3:0] CONV_CHAN_O,
    output wire CONV_CYCLE_DONE_O,
    // ready pin sources
    input wire NEW_DATA_FLAG_I,
    input wire CONV_READY_I,
    // shared ready pin
    output wire SHARED_READY_PIN_O,
    output wire SHARED_READY_PIN_OE_O,
    // supply alarm and amplifier
    input wire NEGATIVE_SUPPLY_ALARM_I,
    output wire AMP_POWER_CONTROL_O,
    // alarms and modes
    output wire [NUM_IN-1:0] ALARM_O,
    output wire REMOTE_PNP_MODE_O
);
    // registers
    reg [15:0] config_q;
    reg [15:0] select_q;
    reg [NUM_IN-1:0] alarm_q;
    reg [NUM_IN-1:0] alarm_d;
    reg supply_alarm_q;
    reg supply_alarm_d;
    reg amp_on_q;
    reg amp_on_d;
    reg ready_pin_q;
    reg ready_oe_q;
    reg ack_q;
    reg [31:0] rdata_q;
    reg [31:0] rdata_d;
    reg supply_meta_q;
    reg supply_sync_q;
    reg supply_prev_q;

    // bus decode
    wire request;
    wire do_write;
    wire [15:0] wmask;
    wire [15:0] wdata;
    wire hit_config;
    wire hit_select;
    wire hit_amp;
    wire hit_clear;
    wire hit_alarm_status;
    wire hit_supply_status;

    assign request = AVS_READ_I | AVS_WRITE_I;
    // one wait cycle, answer on the second edge
    assign AVS_WAITREQUEST_O = request & ~ack_q;
    assign do_write = AVS_WRITE_I & ack_q;
    assign wmask = {{8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
    assign wdata = AVS_WRITEDATA_I[15:0];
    assign hit_config = (AVS_ADDRESS_I == `REG_MONITOR_CONFIG_ONE);
    assign hit_select = (AVS_ADDRESS_I == `REG_ADC_CHANNEL_SELECT);
    assign hit_alarm_status = (AVS_ADDRESS_I == `REG_ALARM_STATUS);
    assign hit_supply_status = (AVS_ADDRESS_I == `REG_SUPPLY_STATUS);
    assign hit_amp = (AVS_ADDRESS_I == `REG_AMP_CONTROL);
    assign hit_clear = (AVS_ADDRESS_I == `REG_ALARM_CLEAR);
    assign AVS_READDATA_O = rdata_q;

    // configuration fields
    wire ready_pin_enable;
    wire ready_pin_function;
    wire [2:0] adc_alarm_filter;
    wire remote_pnp_mode;
    wire supply_alarm_amp_off;
    wire [1:0] local_temp_alarm_filter;
    wire [1:0] remote2_alarm_filter;
    wire [1:0] remote1_alarm_filter;

    assign ready_pin_enable = config_q[`POS_READY_PIN_ENABLE];
    assign ready_pin_function = config_q[`POS_READY_PIN_FUNCTION];
    assign adc_alarm_filter = config_q[`POS_ADC_FILTER_HI:`POS_ADC_FILTER_LO];
    assign remote_pnp_mode = config_q[`POS_REMOTE_PNP_MODE];
    assign supply_alarm_amp_off = config_q[`POS_SUPPLY_ALARM_AMP_OFF];
    assign local_temp_alarm_filter = config_q[`POS_LOCAL_FILTER_HI:`POS_LOCAL_FILTER_LO];
    assign remote2_alarm_filter = config_q[`POS_REMOTE2_FILTER_HI:`POS_REMOTE2_FILTER_LO];
    assign remote1_alarm_filter = config_q[`POS_REMOTE1_FILTER_HI:`POS_REMOTE1_FILTER_LO];

    // run lengths per filter code
    wire [`FILTER_COUNT_WIDTH-1:0] adc_threshold;
    wire [`FILTER_COUNT_WIDTH-1:0] local_threshold;
    wire [`FILTER_COUNT_WIDTH-1:0] remote2_threshold;
    wire [`FILTER_COUNT_WIDTH-1:0] remote1_threshold;

    reg [`FILTER_COUNT_WIDTH-1:0] adc_threshold_d;

    // converter run length per filter code, full table so code 111 cannot wrap
    always @* begin
        case (adc_alarm_filter)
            3'h0: adc_threshold_d = `ADC_RUN_CODE0;
            3'h1: adc_threshold_d = `ADC_RUN_CODE1;
            3'h2: adc_threshold_d = `ADC_RUN_CODE2;
            3'h3: adc_threshold_d = `ADC_RUN_CODE3;
            3'h4: adc_threshold_d = `ADC_RUN_CODE4;
            3'h5: adc_threshold_d = `ADC_RUN_CODE5;
            3'h6: adc_threshold_d = `ADC_RUN_CODE6;
            3'h7: adc_threshold_d = `ADC_RUN_CODE7;
            default: adc_threshold_d = `ADC_RUN_CODE0;
        endcase
    end
    assign adc_threshold = adc_threshold_d;
    assign local_threshold = 9'h001 << local_temp_alarm_filter;
    assign remote2_threshold = 9'h001 << remote2_alarm_filter;
    assign remote1_threshold = 9'h001 << remote1_alarm_filter;

    // per-input filters
    wire [NUM_IN-1:0] filter_hit;
    genvar g;
    generate
        for (g = 0; g < NUM_IN; g = g + 1) begin : chan
            wire [`FILTER_COUNT_WIDTH-1:0] thr;
            wire strobe;
            assign strobe = SAMPLE_VALID_I & (SAMPLE_CHAN_I == g);
            if (g == `POS_LOCAL_TEMP_SELECT) begin : lt
                assign thr = local_threshold;
            end else if (g == `POS_REMOTE_TWO_SELECT) begin : r2
                assign thr = remote2_threshold;
            end else if (g == `POS_REMOTE_ONE_SELECT) begin : r1
                assign thr = remote1_threshold;
            end else begin : adc
                assign thr = adc_threshold;
            end
            run_filter #(
                .WIDTH(`FILTER_COUNT_WIDTH)
            ) u_filter (
                .clk_i(MCLK_I),
                .resetn_i(RESETN_I),
                .sample_i(strobe),
                .out_of_range_i(SAMPLE_OUT_OF_RANGE_I),
                .threshold_i(thr),
                .hit_o(filter_hit[g])
            );
        end
    endgenerate

    // conversion walk over selected inputs
    mux_scanner #(
        .N(NUM_IN)
    ) u_scanner (
        .clk_i(MCLK_I),
        .resetn_i(RESETN_I),
        .start_i(CONV_START_I),
        .select_i(select_q[NUM_IN-1:0]),
        .done_i(CONV_DONE_I),
        .req_o(CONV_REQ_O),
        .chan_o(CONV_CHAN_O),
        .cycle_done_o(CONV_CYCLE_DONE_O)
    );

    // supply alarm pin synchroniser
    always @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            supply_meta_q <= 1'b0;
            supply_sync_q <= 1'b0;
            supply_prev_q <= 1'b0;
        end else begin
            supply_meta_q <= NEGATIVE_SUPPLY_ALARM_I;
            supply_sync_q <= supply_meta_q;
            supply_prev_q <= supply_sync_q;
        end
    end

    wire supply_event;
    assign supply_event = supply_sync_q & ~supply_prev_q;

    // sticky alarms, set wins over clear
    always @* begin
        alarm_d = alarm_q;
        supply_alarm_d = supply_alarm_q;
        if (do_write && hit_clear) begin
            alarm_d = alarm_q & ~wdata[NUM_IN-1:0];
            if (wdata[15]) begin
                supply_alarm_d = 1'b0;
            end
        end
        alarm_d = alarm_d | filter_hit;
        if (supply_sync_q) begin
            supply_alarm_d = 1'b1;
        end
    end

    // amplifier state
    wire amp_locked;
    assign amp_locked = supply_alarm_amp_off & supply_alarm_q;

    always @* begin
        amp_on_d = amp_on_q;
        if (do_write && hit_amp && wmask[`POS_AMP_ON_REQUEST]) begin
            if (!wdata[`POS_AMP_ON_REQUEST]) begin
                amp_on_d = 1'b0;
            end else if (!amp_locked) begin
                amp_on_d = 1'b1;
            end
        end
        // with the cut-off bit clear the event is ignored
        if (supply_alarm_amp_off && (supply_event || supply_sync_q)) begin
            amp_on_d = 1'b0;
        end
    end

    // read mux
    always @* begin
        rdata_d = 32'h0000_0000;
        if (hit_config) begin
            rdata_d[15:0] = config_q;
        end else if (hit_select) begin
            rdata_d[15:0] = select_q;
        end else if (hit_alarm_status) begin
            rdata_d[NUM_IN-1:0] = alarm_q;
        end else if (hit_supply_status) begin
            rdata_d[`POS_SUPPLY_ALARM] = supply_alarm_q;
            rdata_d[`POS_SUPPLY_LEVEL] = supply_sync_q;
            rdata_d[`POS_AMP_STATE] = amp_on_q;
        end else if (hit_amp) begin
            rdata_d[`POS_AMP_ON_REQUEST] = amp_on_q;
        end
    end

    // bus handshake and register writes
    always @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            config_q <= `RST_MONITOR_CONFIG_ONE;
            select_q <= `RST_ADC_CHANNEL_SELECT;
            alarm_q <= {NUM_IN{1'b0}};
            supply_alarm_q <= 1'b0;
            amp_on_q <= 1'b0;
        end else begin
            ack_q <= request & ~ack_q;
            if (AVS_READ_I && !ack_q) begin
                rdata_q <= rdata_d;
            end
            if (do_write && hit_config) begin
                // factory bits stored as written, software keeps them zero
                config_q <= (config_q & ~wmask) | (wdata & wmask);
            end
            if (do_write && hit_select) begin
                select_q <= (select_q & ~wmask) | (wdata & wmask);
            end
            alarm_q <= alarm_d;
            supply_alarm_q <= supply_alarm_d;
            amp_on_q <= amp_on_d;
        end
    end

    // shared ready pin
    always @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            ready_pin_q <= 1'b0;
            ready_oe_q <= 1'b0;
        end else begin
            ready_oe_q <= ready_pin_enable;
            if (!ready_pin_enable) begin
                ready_pin_q <= 1'b0;
            end else if (ready_pin_function == `READY_FN_NEW_DATA) begin
                ready_pin_q <= NEW_DATA_FLAG_I;
            end else begin
                ready_pin_q <= CONV_READY_I;
            end
        end
    end

    assign SHARED_READY_PIN_O = ready_pin_q;
    assign SHARED_READY_PIN_OE_O = ready_oe_q;
    assign AMP_POWER_CONTROL_O = amp_on_q;
    assign ALARM_O = alarm_q;
    assign REMOTE_PNP_MODE_O = remote_pnp_mode;
endmodule
`default_nettype wire

// [logic/alarm_filter_consts.vh]
// register offsets, field positions, reset values and counts of the alarm-filter configuration bank
// assumes word-addressed slave: byte address is four times the register index
`ifndef ALARM_FILTER_CONSTS_VH
`define ALARM_FILTER_CONSTS_VH

// register indices
`define REG_MONITOR_CONFIG_ONE 8'h11
`define REG_ADC_CHANNEL_SELECT 8'h12
`define REG_ALARM_STATUS 8'h20
`define REG_SUPPLY_STATUS 8'h21
`define REG_AMP_CONTROL 8'h22
`define REG_ALARM_CLEAR 8'h23

// reset values
`define RST_MONITOR_CONFIG_ONE 16'h036a
`define RST_ADC_CHANNEL_SELECT 16'h0000

// monitor_config_one fields
`define POS_READY_PIN_ENABLE 15
`define POS_READY_PIN_FUNCTION 14
`define POS_RESERVED_HI 13
`define POS_RESERVED_LO 11
`define POS_ADC_FILTER_HI 10
`define POS_ADC_FILTER_LO 8
`define POS_REMOTE_PNP_MODE 7
`define POS_SUPPLY_ALARM_AMP_OFF 6
`define POS_LOCAL_FILTER_HI 5
`define POS_LOCAL_FILTER_LO 4
`define POS_REMOTE2_FILTER_HI 3
`define POS_REMOTE2_FILTER_LO 2
`define POS_REMOTE1_FILTER_HI 1
`define POS_REMOTE1_FILTER_LO 0

// adc_channel_select fields
`define POS_SELECT_RESERVED 15
`define POS_LOCAL_TEMP_SELECT 14
`define POS_REMOTE_TWO_SELECT 13
`define POS_REMOTE_ONE_SELECT 12
`define POS_CURRENT_SENSE_LO 8
`define POS_EXTERNAL_IN_LO 4
`define POS_INTERNAL_IN_LO 0

// supply status / amp control fields
`define POS_SUPPLY_ALARM 0
`define POS_SUPPLY_LEVEL 1
`define POS_AMP_STATE 2
`define POS_AMP_ON_REQUEST 0

// channel counts and filter sizes
`define NUM_INPUTS 15
`define NUM_ADC_INPUTS 12
`define FILTER_COUNT_WIDTH 9

// converter false-alarm run lengths per filter code
`define ADC_RUN_CODE0 9'h001
`define ADC_RUN_CODE1 9'h004
`define ADC_RUN_CODE2 9'h008
`define ADC_RUN_CODE3 9'h010
`define ADC_RUN_CODE4 9'h020
`define ADC_RUN_CODE5 9'h040
`define ADC_RUN_CODE6 9'h080
`define ADC_RUN_CODE7 9'h100

// ready pin function codes
`define READY_FN_NEW_DATA 1'b0
`define READY_FN_CONV_READY 1'b1

`endif

// [logic/mux_scanner.v]
// walks the selected multiplexer inputs once per conversion cycle
// assumes the converter answers each request with a one-cycle done strobe
`timescale 1ns/1ps
`default_nettype none
module mux_scanner #(
    parameter N = 15
) (
    input wire clk_i,
    input wire resetn_i,
    input wire start_i,
    input wire [N-1:0] select_i,
    input wire done_i,
    output reg req_o,
    output reg [3:0] chan_o,
    output reg cycle_done_o
);
    localparam IDLE = 1'b0;
    localparam BUSY = 1'b1;
    reg state_q;
    reg [N-1:0] pending_q;
    reg [3:0] first_idx;
    integer k;

    // lowest pending input
    always @* begin
        first_idx = 4'h0;
        for (k = N - 1; k >= 0; k = k - 1) begin
            if (pending_q[k]) begin
                first_idx = k[3:0];
            end
        end
    end

    always @(posedge clk_i) begin
        if (!resetn_i) begin
            state_q <= IDLE;
            pending_q <= {N{1'b0}};
            req_o <= 1'b0;
            chan_o <= 4'h0;
            cycle_done_o <= 1'b0;
        end else begin
            cycle_done_o <= 1'b0;
            case (state_q)
                IDLE: begin
                    if (start_i) begin
                        pending_q <= select_i;
                        state_q <= BUSY;
                    end
                end
                BUSY: begin
                    if (pending_q == {N{1'b0}}) begin
                        req_o <= 1'b0;
                        cycle_done_o <= 1'b1;
                        state_q <= IDLE;
                    end else if (!req_o) begin
                        req_o <= 1'b1;
                        chan_o <= first_idx;
                    end else if (done_i) begin
                        req_o <= 1'b0;
                        pending_q[chan_o] <= 1'b0;
                    end
                end
                default: begin
                    state_q <= IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// [logic/run_filter.v]
// consecutive out-of-range sample counter for one channel
// assumes samples arrive as one-cycle strobes on the same clock
`timescale 1ns/1ps
`default_nettype none
module run_filter #(
    parameter WIDTH = 9
) (
    input wire clk_i,
    input wire resetn_i,
    input wire sample_i,
    input wire out_of_range_i,
    input wire [WIDTH-1:0] threshold_i,
    output wire hit_o
);
    reg [WIDTH-1:0] count_q;
    reg [WIDTH-1:0] count_d;
    wire [WIDTH:0] next_count;

    assign next_count = {1'b0, count_q} + {{WIDTH{1'b0}}, 1'b1};
    // raise once the run reaches the selected length
    assign hit_o = sample_i & out_of_range_i & (next_count >= {1'b0, threshold_i});

    always @* begin
        count_d = count_q;
        if (sample_i) begin
            if (!out_of_range_i) begin
                count_d = {WIDTH{1'b0}};
            end else if (next_count < {1'b0, threshold_i}) begin
                count_d = next_count[WIDTH-1:0];
            end else begin
                count_d = threshold_i;
            end
        end
    end

    always @(posedge clk_i) begin
        if (!resetn_i) begin
            count_q <= {WIDTH{1'b0}};
        end else begin
            count_q <= count_d;
        end
    end
endmodule
`default_nettype wire

// [sim/alarm_filter_config_props.sv]
// assertions for the alarm-filter configuration bank
// assumes binding to alarm_filter_config; mirrors config and select from bus writes
`timescale 1ns/1ps
`default_nettype none
`include "alarm_filter_consts.vh"
module alarm_filter_config_props #(
    parameter ADDR_WIDTH = 8,
    parameter NUM_IN = 15
) (
    // clock and reset
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    // bus
    input wire logic [ADDR_WIDTH-1:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    input wire logic AVS_WAITREQUEST_O,
    // samples and conversion
    input wire logic SAMPLE_VALID_I,
    input wire logic [3:0] SAMPLE_CHAN_I,
    input wire logic SAMPLE_OUT_OF_RANGE_I,
    input wire logic CONV_DONE_I,
    input wire logic CONV_REQ_O,
    input wire logic [3:0] CONV_CHAN_O,
    // pin, amplifier, alarms
    input wire logic NEW_DATA_FLAG_I,
    input wire logic CONV_READY_I,
    input wire logic SHARED_READY_PIN_O,
    input wire logic SHARED_READY_PIN_OE_O,
    input wire logic NEGATIVE_SUPPLY_ALARM_I,
    input wire logic AMP_POWER_CONTROL_O,
    input wire logic [NUM_IN-1:0] ALARM_O,
    input wire logic REMOTE_PNP_MODE_O
);
    logic [15:0] cfg_q;
    logic [15:0] sel_q;
    wire wr_acc = AVS_WRITE_I && !AVS_WAITREQUEST_O;
    wire [15:0] mask = {{8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
    wire [15:0] wdat = AVS_WRITEDATA_I[15:0];
    wire amp_wr = wr_acc && AVS_ADDRESS_I == `REG_AMP_CONTROL;
    wire pin_src = cfg_q[14] ? CONV_READY_I : NEW_DATA_FLAG_I;
    wire [NUM_IN-1:0] hit = (SAMPLE_VALID_I && SAMPLE_OUT_OF_RANGE_I) ?
        ({{(NUM_IN-1){1'b0}}, 1'b1} << SAMPLE_CHAN_I) : {NUM_IN{1'b0}};
    // register mirror
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            cfg_q <= `RST_MONITOR_CONFIG_ONE;
            sel_q <= `RST_ADC_CHANNEL_SELECT;
        end else if (wr_acc && AVS_ADDRESS_I == `REG_MONITOR_CONFIG_ONE) begin
            cfg_q <= (cfg_q & ~mask) | (wdat & mask);
        end else if (wr_acc && AVS_ADDRESS_I == `REG_ADC_CHANNEL_SELECT) begin
            sel_q <= (sel_q & ~mask) | (wdat & mask);
        end
    end
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RESETN_I);
    wait_one_a: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
        else $error("waitrequest held too long");
    pin_oe_a: assert property (SHARED_READY_PIN_OE_O == $past(cfg_q[15]))
        else $error("ready pin enable wrong");
    pin_value_a: assert property ($past(cfg_q[15]) |-> SHARED_READY_PIN_O == $past(pin_src))
        else $error("ready pin value wrong");
    amp_off_a: assert property ((cfg_q[6] && NEGATIVE_SUPPLY_ALARM_I) [*6] |-> !AMP_POWER_CONTROL_O)
        else $error("amplifier not forced off");
    amp_free_a: assert property ($changed(AMP_POWER_CONTROL_O) && !$past(cfg_q[6]) |-> $past(amp_wr))
        else $error("amplifier changed without write");
    alarm_cause_a: assert property ((ALARM_O & ~$past(ALARM_O)) == '0 || (ALARM_O & ~$past(ALARM_O)) == $past(hit))
        else $error("alarm rose without sample");
    remote_one_a: assert property (cfg_q[1:0] == 2'b00 && hit[12] |=> ALARM_O[12])
        else $error("single-sample remote alarm missed");
    conv_drop_a: assert property (CONV_REQ_O && CONV_DONE_I |=> !CONV_REQ_O)
        else $error("request not dropped after done");
    req_select_a: assert property (CONV_REQ_O |-> sel_q[CONV_CHAN_O])
        else $error("unselected input converted");
    pnp_mode_a: assert property (REMOTE_PNP_MODE_O == cfg_q[7])
        else $error("pnp mode output wrong");
    cover property (hit[14] ##1 ALARM_O[14]);
    cover property (CONV_REQ_O && CONV_DONE_I);
    cover property ($fell(AMP_POWER_CONTROL_O) && NEGATIVE_SUPPLY_ALARM_I);
endmodule
bind alarm_filter_config alarm_filter_config_props #(.ADDR_WIDTH(ADDR_WIDTH), .NUM_IN(NUM_IN)) props (.*);
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench for the alarm-filter configuration bank
// assumes design, header and checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "alarm_filter_consts.vh"
module tb_top;
    logic clk = 0;
    logic rst_n = 0;
    logic rd = 0, wr = 0, sv = 0, oor = 0, cst = 0, cdn = 0, nd = 0, cr = 0, neg = 0;
    logic [7:0] adr = 0;
    logic [31:0] wd = 0;
    logic [3:0] be = 0, sch = 0;
    logic [31:0] rv;
    wire [31:0] rdat;
    wire wrq, creq, cdone, pin, poe, amp, pnp;
    wire [3:0] cch;
    wire [14:0] alm;
    int err_total = 0;
    int checks_done = 0;
    always #4 clk = ~clk;
    alarm_filter_config dut (
        .MCLK_I(clk), .RESETN_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
        .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wrq),
        .SAMPLE_VALID_I(sv), .SAMPLE_CHAN_I(sch), .SAMPLE_OUT_OF_RANGE_I(oor), .CONV_START_I(cst),
        .CONV_DONE_I(cdn), .CONV_REQ_O(creq), .CONV_CHAN_O(cch), .CONV_CYCLE_DONE_O(cdone),
        .NEW_DATA_FLAG_I(nd), .CONV_READY_I(cr), .SHARED_READY_PIN_O(pin), .SHARED_READY_PIN_OE_O(poe),
        .NEGATIVE_SUPPLY_ALARM_I(neg), .AMP_POWER_CONTROL_O(amp), .ALARM_O(alm), .REMOTE_PNP_MODE_O(pnp)
    );
    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one bus cycle, held until waitrequest low
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= {16'h0000, d};
        be <= b;
        do begin
            @(posedge clk);
            n++;
        end while (wrq !== 1'b0 && n < 20);
        if (wrq !== 1'b0) begin
            chk("bus waitrequest", wrq, 32'h0);
            finish_test();
        end else begin
            rv = rdat;
            rd <= 0;
            wr <= 0;
        end
    endtask
    task automatic wrr(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, d, 4'h3);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 16'h0000, 4'h3);
        chk(nm, rv, e);
    endtask
    task automatic samp(input logic [3:0] c, input logic o, input int k);
        repeat (k) begin
            @(posedge clk);
            sv <= 1;
            sch <= c;
            oor <= o;
            @(posedge clk);
            sv <= 0;
        end
    endtask
    task automatic filt(input logic [3:0] c, input int cnt);
        samp(c, 1'b0, 1);
        samp(c, 1'b1, cnt - 1);
        samp(c, 1'b0, 1);
        samp(c, 1'b1, cnt - 1);
        @(negedge clk);
        chk("alarm early", {17'h0, alm}, 32'h0);
        samp(c, 1'b1, 1);
        @(negedge clk);
        chk("alarm set", {17'h0, alm}, 32'h1 << c);
        wrr(`REG_ALARM_CLEAR, 16'h1 << c);
        @(negedge clk);
        chk("alarm clear", {17'h0, alm}, 32'h0);
    endtask
    task automatic t_reset;
        rdc("config reset", `REG_MONITOR_CONFIG_ONE, 32'h036a);
        rdc("select reset", `REG_ADC_CHANNEL_SELECT, 32'h0);
        chk("pin oe reset", poe, 0);
        chk("pnp reset", pnp, 0);
        wrr(`REG_ADC_CHANNEL_SELECT, 16'hffff);
        rdc("select all", `REG_ADC_CHANNEL_SELECT, 32'hffff);
        bus(1'b1, `REG_ADC_CHANNEL_SELECT, 16'h0000, 4'h1);
        rdc("select lane", `REG_ADC_CHANNEL_SELECT, 32'hff00);
        wrr(8'h3f, 16'h1234);
        rdc("unmapped", 8'h3f, 32'h0);
        rdc("config kept", `REG_MONITOR_CONFIG_ONE, 32'h036a);
        wrr(`REG_MONITOR_CONFIG_ONE, 16'h03ea);
        @(negedge clk);
        chk("pnp set", pnp, 1);
    endtask
    task automatic t_pin;
        for (int k = 0; k < 8; k++) begin
            wrr(`REG_MONITOR_CONFIG_ONE, {k[1], k[0], 14'h036a});
            nd <= k[2];
            cr <= !k[2];
            repeat (2) @(negedge clk);
            chk("pin oe", poe, k[1]);
            if (k[1]) begin
                chk("pin value", pin, k[0] ? !k[2] : k[2]);
            end
        end
    endtask
    task automatic t_amp;
        int n;
        wrr(`REG_MONITOR_CONFIG_ONE, 16'h036a);
        wrr(`REG_AMP_CONTROL, 16'h1);
        @(posedge clk);
        neg <= 1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (amp !== 1'b0 && n < 10);
        chk("amp forced off", amp, 0);
        if (amp !== 1'b0) finish_test();
        wrr(`REG_AMP_CONTROL, 16'h1);
        @(posedge clk);
        neg <= 0;
        repeat (6) @(negedge clk);
        wrr(`REG_AMP_CONTROL, 16'h1);
        @(negedge clk);
        chk("amp held off", amp, 0);
        wrr(`REG_ALARM_CLEAR, 16'h8000);
        wrr(`REG_AMP_CONTROL, 16'h1);
        @(negedge clk);
        chk("amp back on", amp, 1);
        wrr(`REG_MONITOR_CONFIG_ONE, 16'h032a);
        @(posedge clk);
        neg <= 1;
        repeat (10) @(negedge clk);
        chk("amp untouched", amp, 1);
        @(posedge clk);
        neg <= 0;
        repeat (6) @(negedge clk);
        wrr(`REG_ALARM_CLEAR, 16'h8000);
    endtask
    task automatic t_filters;
        int adc_n[8] = '{1, 4, 8, 16, 32, 64, 128, 256};
        for (int k = 0; k < 8; k++) begin
            wrr(`REG_MONITOR_CONFIG_ONE, {5'b00000, k[2:0], 8'h6a});
            filt(k[3:0], adc_n[k]);
        end
        for (int k = 0; k < 4; k++) begin
            wrr(`REG_MONITOR_CONFIG_ONE, {8'h03, 2'b01, k[1:0], k[1:0], k[1:0]});
            filt(4'd12, 1 << k);
            filt(4'd13, 1 << k);
            filt(4'd14, 1 << k);
        end
    endtask
    task automatic t_conv;
        logic [3:0] exp_ch[3] = '{4'd0, 4'd4, 4'd14};
        int n;
        wrr(`REG_ADC_CHANNEL_SELECT, 16'h4011);
        @(posedge clk);
        cst <= 1;
        @(posedge clk);
        cst <= 0;
        for (int i = 0; i < 3; i++) begin
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (creq !== 1'b1 && n < 20);
            chk("conv chan", {creq, cch}, {1'b1, exp_ch[i]});
            if (creq !== 1'b1) finish_test();
            @(posedge clk);
            cdn <= 1;
            @(posedge clk);
            cdn <= 0;
        end
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (cdone !== 1'b1 && n < 20);
        chk("cycle done", {creq, cdone}, 2'b01);
        if (cdone !== 1'b1) finish_test();
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1;
        t_reset();
        t_pin();
        t_amp();
        t_filters();
        t_conv();
        finish_test();
    end
endmodule
`default_nettype wire
